// *** verilog/tzu_timer_zero_unit.sv ***
// timer zero unit: 8-bit timer/counter with a prescaler shared with
// the watchdog, registers on AHB-Lite, two interrupt lines, OVF_REQ and IRQ.
// assumes sleep, watchdog tick and watchdog clear come from logic on
// CLK; the count pin is asynchronous and is synchronised here.
//
// Overview of operation
// - clear source bit: count instruction cycles
// - count write blocks two instruction cycles
// - set source bit: count count-pin edges
// - edge bit picks rising or falling edge
// - pin synchronised, update at next cycle
// - one prescaler serves counter or watchdog
// - prescaler neither readable nor loadable
// - owner bit and ratio in bits 3:0
// - counter owner: ratios 1:2 to 1:256
// - watchdog owner: ratios 1:1 to 1:128
// - count write clears prescaler when counter owns it, keeps owner
// - watchdog clear clears prescaler when watchdog owns it
// - owner may change at any time
// - roll FFh to 00h sets overflow flag
// - enable bit gates overflow request
// - counter stopped during sleep
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
module tzu_timer_zero_unit
  import tzu_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // count pin
  input wire logic EXT_COUNT_PIN,
  // core side
  input wire logic SLEEP,
  input wire logic WDT_TICK,
  input wire logic WDT_CLR,
  output logic WDT_POST_TICK,
  output logic OVF_REQ,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam tzu_state_type ST_RST = '{
    bus: BUS_IDLE,
    timer_count: TIMER_COUNT_RST,
    option_config: OPTION_CONFIG_RST,
    interrupt_control: INTERRUPT_CONTROL_RST,
    default: '0
  };

  tzu_state_type r;
  tzu_state_type n;

  logic addr_take;
  logic wr_now;
  logic [7:0] wdat;
  logic cnt_wr;
  logic opt_wr;
  logic int_wr;
  logic stat_wr;
  logic mask_wr;
  logic owner_wdt;
  logic ext_mode;
  logic ext_edge;
  logic src_evt;
  logic evt_ok;
  logic adv;
  logic ovf;
  logic [7:0] tmask;
  logic [7:0] wmask;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // bus address phase and data phase strobes
    addr_take = HSEL && HTRANS[1] && HREADY;
    wr_now = (r.bus == BUS_WRITE);
    wdat = HWDATA[7:0];
    cnt_wr = wr_now && (r.idx == IDX_TIMER_COUNT);
    opt_wr = wr_now && (r.idx == IDX_OPTION_CONFIG);
    int_wr = wr_now && (r.idx == IDX_INTERRUPT_CONTROL);
    stat_wr = wr_now && (r.idx == IDX_IRQ_STATUS);
    mask_wr = wr_now && (r.idx == IDX_IRQ_MASK);
    owner_wdt = r.option_config[BIT_PRESCALER_OWNER_SEL];
    ext_mode = r.option_config[BIT_CLOCK_SOURCE_SEL];

    // instruction cycle enable, one pulse every four clocks
    n.div = (r.div == DIV_LAST) ? 2'h0 : 2'(r.div + 2'h1);
    n.icyc = (r.div == DIV_LAST);

    // pin synchroniser, only the second and third stage are looked at
    n.ext_s1 = EXT_COUNT_PIN;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    // edge bit clear picks the rising edge, set the falling one
    if (r.option_config[BIT_SOURCE_EDGE_SEL]) begin
      ext_edge = r.ext_s3 && !r.ext_s2;
    end else begin
      ext_edge = !r.ext_s3 && r.ext_s2;
    end

    // source events: a synchronised edge waits for the next cycle
    src_evt = 1'b0;
    if (SLEEP) begin
      n.edge_pend = 1'b0;
    end else if (ext_mode) begin
      src_evt = r.icyc && r.edge_pend;
      n.edge_pend = r.icyc ? ext_edge : (r.edge_pend || ext_edge);
    end else begin
      src_evt = r.icyc;
      n.edge_pend = 1'b0;
    end

    // after a count write the next two instruction cycles are lost
    evt_ok = src_evt && (r.inhib == 2'h0);
    if (r.icyc && !SLEEP && (r.inhib != 2'h0)) begin
      n.inhib = 2'(r.inhib - 2'h1);
    end

    // one shared divider: low bits all ones mark the ratio point
    tmask = 8'((9'h002 << r.option_config[2:0]) - 9'h001);
    wmask = 8'((9'h001 << r.option_config[2:0]) - 9'h001);
    adv = 1'b0;
    n.wdt_post = 1'b0;
    if (!owner_wdt) begin
      if (evt_ok) begin
        adv = ((r.pre & tmask) == tmask);
        n.pre = 8'(r.pre + 8'h01);
      end
    end else begin
      adv = evt_ok;
      if (WDT_TICK) begin
        n.wdt_post = ((r.pre & wmask) == wmask);
        n.pre = 8'(r.pre + 8'h01);
      end
      // watchdog clear also empties the shared divider
      if (WDT_CLR) begin
        n.pre = 8'h00;
      end
    end

    // counter advance and roll-over
    ovf = adv && (r.timer_count == 8'hff);
    if (adv) begin
      n.timer_count = 8'(r.timer_count + 8'h01);
    end
    // a software write beats a same-cycle advance and its roll-over
    if (cnt_wr) begin
      n.timer_count = wdat;
      n.inhib = WR_INHIBIT_ICYC;
      ovf = 1'b0;
      if (!owner_wdt) begin
        n.pre = 8'h00;
      end
    end

    // configuration, owner may be switched while running
    if (opt_wr) begin
      n.option_config = wdat;
    end

    // overflow flag: hardware set wins over a software clear
    if (int_wr) begin
      n.interrupt_control = wdat;
    end
    if (ovf) begin
      n.interrupt_control[BIT_OVERFLOW_FLAG] = 1'b1;
    end

    // sticky status, write one to clear, new events win
    if (stat_wr) begin
      n.irq_status = r.irq_status & ~wdat[1:0];
    end
    n.irq_status[IRQ_BIT_OVERFLOW] = n.irq_status[IRQ_BIT_OVERFLOW] | ovf;
    n.irq_status[IRQ_BIT_WDT_POST] = n.irq_status[IRQ_BIT_WDT_POST] | n.wdt_post;
    if (mask_wr) begin
      n.irq_mask = wdat[1:0];
    end

    // read mux, prescaler has no address on purpose
    unique case (r.idx)
      IDX_TIMER_COUNT: rd_byte = r.timer_count;
      IDX_INTERRUPT_CONTROL: rd_byte = r.interrupt_control;
      IDX_OPTION_CONFIG: rd_byte = r.option_config;
      IDX_IRQ_STATUS: rd_byte = {6'h00, r.irq_status};
      IDX_IRQ_MASK: rd_byte = {6'h00, r.irq_mask};
      default: rd_byte = 8'h00;
    endcase

    // bus phases: writes take no wait, reads take one wait state
    // so that read data never sees a write still in flight
    unique case (r.bus)
      BUS_RD_WAIT: begin
        n.hrdata = {24'h000000, rd_byte};
        n.bus = BUS_RD_DONE;
      end
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (addr_take) begin
          n.idx = HADDR[11:2];
          n.bus = HWRITE ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          n.bus = BUS_IDLE;
        end
      end
      default: begin
        n.bus = BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every answer is okay, unmapped words read zero
  assign HRDATA = r.hrdata;
  assign HREADYOUT = (r.bus != BUS_RD_WAIT);
  assign HRESP = 1'b0;
  assign WDT_POST_TICK = r.wdt_post;
  // level request; flag stays until software clears it
  assign OVF_REQ = r.interrupt_control[BIT_OVERFLOW_IRQ_EN] &&
                   r.interrupt_control[BIT_OVERFLOW_FLAG];
  assign IRQ = |(r.irq_status & r.irq_mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // no write, no sleep, no inhibit, count pin mode without prescaler
  logic quiet_ext;
  assign quiet_ext = !cnt_wr && !SLEEP && (r.inhib == 2'h0) && ext_mode && owner_wdt
                     && !opt_wr;

  sequence s_ext_edge;
    ext_edge && quiet_ext;
  endsequence

  sequence s_quiet_four;
    quiet_ext[*4];
  endsequence

  chk_write_inhibit: assert property (
    (r.inhib != 2'h0) && !cnt_wr |=> r.timer_count == $past(r.timer_count))
    else $error("count moved during write inhibit");

  chk_timer_advance: assert property (
    r.icyc && !ext_mode && owner_wdt && (r.inhib == 2'h0) && !SLEEP && !cnt_wr
    |=> r.timer_count == 8'($past(r.timer_count) + 8'h01))
    else $error("timer mode did not advance on instruction cycle");

  chk_ext_advance: assert property (
    s_ext_edge ##1 s_quiet_four |=> r.timer_count != $past(r.timer_count, 5))
    else $error("count pin edge was not counted");

  chk_overflow_flag: assert property (
    $past(r.timer_count) == 8'hff && r.timer_count == 8'h00 && !$past(cnt_wr)
    |-> r.interrupt_control[BIT_OVERFLOW_FLAG])
    else $error("roll-over did not set overflow flag");

  chk_overflow_gate: assert property (
    !r.interrupt_control[BIT_OVERFLOW_IRQ_EN] |-> !OVF_REQ)
    else $error("overflow request not gated by enable");

  chk_sleep_hold: assert property (
    SLEEP && !cnt_wr |=> r.timer_count == $past(r.timer_count))
    else $error("counter advanced during sleep");

  chk_prescale_clear: assert property (
    cnt_wr && !owner_wdt |=> r.pre == 8'h00 && $stable(r.option_config))
    else $error("count write did not clear prescaler");

  chk_wdt_clear: assert property (
    WDT_CLR && owner_wdt && !opt_wr |=> r.pre == 8'h00)
    else $error("watchdog clear did not clear prescaler");

  chk_prescale_gate: assert property (
    !owner_wdt && !cnt_wr && ((r.pre & tmask) != tmask) |=> $stable(r.timer_count))
    else $error("count advanced off the divided output");

  // a count write loads the byte and arms the two-cycle hold
  chk_write_load: assert property (
    cnt_wr |=> r.timer_count == $past(wdat) && r.inhib == WR_INHIBIT_ICYC)
    else $error("count write did not load or arm the hold");

  chk_inhib_decay: assert property (
    r.icyc && !SLEEP && (r.inhib != 2'h0) && !cnt_wr
    |=> r.inhib == 2'($past(r.inhib) - 2'h1))
    else $error("write hold did not run down per instruction cycle");

  // edges are parked until the next instruction cycle, dropped in sleep
  chk_edge_pend: assert property (
    !SLEEP && ext_mode && ext_edge |=> r.edge_pend)
    else $error("synchronised pin edge was not parked");

  chk_sleep_drop: assert property (
    SLEEP |=> !r.edge_pend)
    else $error("pin edge kept across sleep");

  // the watchdog side of the divider must not see counter events
  chk_wdt_hold: assert property (
    owner_wdt && !WDT_TICK && !WDT_CLR |=> $stable(r.pre))
    else $error("shared divider moved without a watchdog event");

  chk_post_owner: assert property (
    !owner_wdt |=> !WDT_POST_TICK)
    else $error("watchdog postscaler ran while the counter owns the divider");

  chk_post_every: assert property (
    owner_wdt && WDT_TICK && (r.option_config[2:0] == 3'h0) |=> WDT_POST_TICK)
    else $error("one to one postscale missed a watchdog tick");

  chk_ratio_advance: assert property (
    !owner_wdt && evt_ok && ((r.pre & tmask) == tmask) && !cnt_wr
    |=> r.timer_count == 8'($past(r.timer_count) + 8'h01))
    else $error("count missed the divided output");

  chk_wrap_status: assert property (
    ovf |=> r.interrupt_control[BIT_OVERFLOW_FLAG] && r.irq_status[IRQ_BIT_OVERFLOW])
    else $error("roll-over did not reach flag and status");

  // the flag only falls when software writes the control register
  chk_flag_sticky: assert property (
    r.interrupt_control[BIT_OVERFLOW_FLAG] && !int_wr
    |=> r.interrupt_control[BIT_OVERFLOW_FLAG])
    else $error("overflow flag fell without a software write");

  chk_owner_switch: assert property (
    opt_wr |=> r.option_config == $past(wdat))
    else $error("configuration write was not taken");

  // a read answers after exactly one wait, upper bytes always zero
  sequence s_read_taken;
    addr_take && !HWRITE && HREADYOUT;
  endsequence

  sequence s_read_answer;
    !HREADYOUT ##1 (HREADYOUT && (HRDATA[31:8] == 24'h000000));
  endsequence

  chk_read_answer: assert property (
    s_read_taken |=> s_read_answer)
    else $error("read answer late or wider than one byte");

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the two-bit divider serves an instruction cycle of one to four clocks
  if ((ICYC_CLKS == 0) || (ICYC_CLKS > 4)) begin : g_bad_icyc
    $error("instruction cycle must span one to four clocks");
  end

endmodule

// *** inc/tzu_pkg.sv ***
// constants, register map and state types of the timer zero unit
// assumes one 20 MHz clock and a 32-bit AHB-Lite register port
package tzu_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ICYC_PERIOD_NS = 200;
  localparam int unsigned ICYC_CLKS = ICYC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_LAST = 2'(ICYC_CLKS - 1);
  localparam logic [1:0] WR_INHIBIT_ICYC = 2'h2;

  // ----------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_TIMER_COUNT = 10'h001;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_OPTION_CONFIG = 10'h081;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0f0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0f1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CLOCK_SOURCE_SEL = 5;
  localparam int unsigned BIT_SOURCE_EDGE_SEL = 4;
  localparam int unsigned BIT_PRESCALER_OWNER_SEL = 3;
  localparam int unsigned BIT_OVERFLOW_FLAG = 2;
  localparam int unsigned BIT_OVERFLOW_IRQ_EN = 5;
  localparam int unsigned IRQ_BIT_OVERFLOW = 0;
  localparam int unsigned IRQ_BIT_WDT_POST = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_CONFIG_RST = 8'hff;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] TIMER_COUNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DONE = 4'h8
  } tzu_bus_type;

  typedef struct packed {
    tzu_bus_type bus;
    logic [9:0] idx;
    logic [31:0] hrdata;
    logic [7:0] timer_count;
    logic [7:0] option_config;
    logic [7:0] interrupt_control;
    logic [7:0] pre;
    logic [1:0] div;
    logic icyc;
    logic [1:0] inhib;
    logic edge_pend;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic wdt_post;
  } tzu_state_type;

endpackage

// *** sim/tzu_count_src.sv ***
// ----------------------------------------------------------------
// count-pin source model for the timer zero unit
// ----------------------------------------------------------------
// assumes a free-running clk to pace its edges; the pin level is held
// between edges, as a plain push-pull source would
`timescale 1ns/10ps
module tzu_count_src (
  // pacing clock
  input wire logic clk,
  // count pin
  output logic pin
);
  initial pin = 1'b0;

  // one level change, then a quiet gap; gap above the sync delay lets
  // every edge be seen on its own, a short gap stresses the synchroniser
  task automatic step(input int gap);
    @(posedge clk);
    pin <= ~pin;
    repeat (gap) @(posedge clk);
  endtask

  // whole pulses: one rising and one falling edge each
  task automatic pulses(input int n);
    repeat (n) begin
      step(8);
      step(8);
    end
  endtask
endmodule

// *** sim/tb_tzu_timer_zero_unit.sv ***
// ----------------------------------------------------------------
// self-checking bench for the timer zero unit
// ----------------------------------------------------------------
// assumes the package, the design and the count-source model are
// compiled first; one ahb-lite master, reads checked from a note queue
`timescale 1ns/10ps
module tb_tzu_timer_zero_unit
  import tzu_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, sleep, wdt_tick, wdt_clr, rd_ph;
  logic hreadyout, hresp, ext_pin, post_tick, ovf_req, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, a, b;
  logic [32:0] exp_q[$];
  logic [7:0] rnd;
  int fails = 0;
  int checks = 0;
  int posts = 0;
  int n;

  tzu_timer_zero_unit tzu_timer_zero_unit_inst (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_COUNT_PIN(ext_pin),
    .SLEEP(sleep), .WDT_TICK(wdt_tick), .WDT_CLR(wdt_clr), .WDT_POST_TICK(post_tick),
    .OVF_REQ(ovf_req), .IRQ(irq));
  tzu_count_src tzu_count_src_inst (.clk(clk), .pin(ext_pin));

  // ----------------------------------------------------------------
  // clock, verdict, checks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // read results: oldest note taken when a read data phase ends
  always @(posedge clk) begin
    if (!rst_n) rd_ph <= 1'b0;
    else if (hreadyout === 1'b1) begin
      if (rd_ph && exp_q.size() > 0 && !exp_q[0][32]) chk("hrdata", exp_q[0][31:0], hrdata);
      if (rd_ph) chk("hresp", 32'h0, {31'h0, hresp});
      if (rd_ph && exp_q.size() > 0) void'(exp_q.pop_front());
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end

  // watchdog postscaler pulses
  always @(posedge clk) if (post_tick === 1'b1) posts <= posts + 1;

  // a hang ends the run through the same closing task
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out;
  end

  // ----------------------------------------------------------------
  // bus and pulse tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
                      input logic [32:0] e, output logic [31:0] got);
    haddr <= {20'h00000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    if (!wr) exp_q.push_back(e);
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] g;
    xfer(idx, 1'b1, d, 33'h0, g);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    logic [31:0] g;
    xfer(idx, 1'b0, 8'h00, {25'h0000000, e}, g);
  endtask

  // read whose value is judged by the caller
  task automatic rdx(input logic [9:0] idx, output logic [31:0] g);
    xfer(idx, 1'b0, 8'h00, 33'h100000000, g);
  endtask

  task automatic wdt_pulse(input logic clr_sel);
    if (clr_sel) wdt_clr <= 1'b1;
    else wdt_tick <= 1'b1;
    @(posedge clk);
    wdt_clr <= 1'b0;
    wdt_tick <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    sleep = 1'b0;
    wdt_tick = 1'b0;
    wdt_clr = 1'b0;
    rnd = 8'h47;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, then an unmapped place that must stay zero
    rd(IDX_OPTION_CONFIG, 8'hff);
    rd(IDX_TIMER_COUNT, 8'h00);
    rd(IDX_INTERRUPT_CONTROL, 8'h00);
    rd(IDX_IRQ_MASK, 8'h00);
    wr(10'h3ff, 8'h55);
    rd(10'h3ff, 8'h00);
    // pin counting, rising then falling edge, three level changes each
    for (int m = 0; m < 2; m++) begin
      wr(IDX_OPTION_CONFIG, (m != 0) ? 8'h38 : 8'h28);
      rnd = lfsr(rnd);
      wr(IDX_TIMER_COUNT, rnd);
      repeat (16) @(posedge clk);
      repeat (3) tzu_count_src_inst.step(12);
      repeat (16) @(posedge clk);
      rd(IDX_TIMER_COUNT, rnd + 8'h02);
    end
    // sleep freezes the count, pending edges are dropped
    wr(IDX_OPTION_CONFIG, 8'h28);
    sleep <= 1'b1;
    tzu_count_src_inst.pulses(3);
    repeat (16) @(posedge clk);
    sleep <= 1'b0;
    rd(IDX_TIMER_COUNT, rnd + 8'h02);
    // counter owns the prescaler: one step short of a second advance
    for (int r = 0; r < 8; r++) begin
      wr(IDX_OPTION_CONFIG, 8'h20 | 8'(r));
      wr(IDX_TIMER_COUNT, 8'h00);
      repeat (16) @(posedge clk);
      tzu_count_src_inst.pulses((4 << r) - 1);
      repeat (16) @(posedge clk);
      rd(IDX_TIMER_COUNT, 8'h01);
    end
    // a count write drops half a prescale period
    wr(IDX_OPTION_CONFIG, 8'h21);
    repeat (2) begin
      wr(IDX_TIMER_COUNT, 8'h00);
      repeat (16) @(posedge clk);
      tzu_count_src_inst.pulses(2);
      repeat (16) @(posedge clk);
    end
    rd(IDX_TIMER_COUNT, 8'h00);
    rd(IDX_OPTION_CONFIG, 8'h21);
    // timer mode, owner moved to the watchdog after a count write
    wr(IDX_TIMER_COUNT, 8'h00);
    wr(IDX_OPTION_CONFIG, 8'h08);
    repeat (16) @(posedge clk);
    rdx(IDX_TIMER_COUNT, a);
    repeat (37) @(posedge clk);
    rdx(IDX_TIMER_COUNT, b);
    chk("timer step", 32'h0000000a, {24'h000000, b[7:0] - a[7:0]});
    // overflow after a write: two instruction cycles lost first
    wr(IDX_TIMER_COUNT, 8'h00);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_TIMER_COUNT, 8'hff);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("inhibit span", 32'h1, {31'h0, n >= 10 && n <= 15});
    chk("ovf_req", 32'h0, {31'h0, ovf_req});
    rd(IDX_INTERRUPT_CONTROL, 8'h04);
    wr(IDX_INTERRUPT_CONTROL, 8'h24);
    repeat (2) @(posedge clk);
    chk("ovf_req", 32'h1, {31'h0, ovf_req});
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // flag cleared by software while the enable stays on
    wr(IDX_INTERRUPT_CONTROL, 8'h20);
    repeat (2) @(posedge clk);
    chk("ovf_req", 32'h0, {31'h0, ovf_req});
    // watchdog owns the prescaler: three postscaled pulses per ratio
    wr(IDX_OPTION_CONFIG, 8'h28);
    for (int r = 0; r < 8; r++) begin
      wr(IDX_OPTION_CONFIG, 8'h28 | 8'(r));
      wdt_pulse(1'b1);
      n = posts;
      repeat (3 << r) wdt_pulse(1'b0);
      repeat (4) @(posedge clk);
      chk("post ticks", 32'h3, 32'(posts - n));
    end
    // watchdog clear drops a half-full prescaler
    wr(IDX_OPTION_CONFIG, 8'h2a);
    n = posts;
    repeat (2) begin
      wdt_pulse(1'b1);
      repeat (2) wdt_pulse(1'b0);
    end
    repeat (4) @(posedge clk);
    chk("post ticks", 32'h0, 32'(posts - n));
    rd(IDX_IRQ_STATUS, 8'h02);
    // let the read checker take its last note before the verdict
    @(posedge clk);
    close_out;
  end
endmodule
